// [rtl/srpd_pkg.sv]
// Shared constants of the SDRAM refresh and power-down control slice.
// Assumes a 32-bit classic Wishbone register port and one 250 MHz clock.
package srpd_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_RTCS = 8'h04;
    localparam logic [7:0] ADR_RCNT = 8'h08;
    localparam logic [7:0] ADR_RCOR = 8'h0c;
    localparam logic [7:0] ADR_STAT = 8'h10;
    localparam int         WB_ADR_W = 8;
    localparam int         WB_DAT_W = 32;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          BIT_DEEP    = 13;
    localparam int          BIT_SLOW    = 12;
    localparam int          BIT_REFEN   = 11;
    localparam int          BIT_RKIND   = 10;
    localparam int          BIT_PDAFT   = 9;
    localparam int          BIT_CMF     = 7;
    localparam int          KEY_LSB     = 16;
    localparam logic [15:0] RTCS_KEY    = 16'ha55a;
    localparam logic        CTRL_RESET  = 1'b0;
    localparam int          STAT_CKE    = 0;
    localparam int          STAT_PD     = 1;
    localparam int          STAT_SELF   = 2;
    localparam int          STAT_RPEND  = 3;

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CAS_LATENCY   = 2;
    localparam int TIMER_DIV     = 4;
    localparam int CNT_WIDTH     = 8;

    // ------------------------------------------------------------------
    // SDRAM commands as {ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_NOP   = 3'h7;
    localparam logic [2:0] CMD_ACT   = 3'h3;
    localparam logic [2:0] CMD_READ  = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_REF   = 3'h1;
    localparam logic [2:0] CMD_BST   = 3'h6;
    localparam int         AP_BIT    = 10;

    typedef enum {
        ST_IDLE,
        ST_RW,
        ST_RD,
        ST_PD,
        ST_SELF,
        ST_WAKE
    } srpd_state_type;

endpackage : srpd_pkg

// [rtl/srpd_refresh_timer.sv]
// Refresh timer: prescaled counter, time constant and compare-match flag.
// Assumes tick_i is a one-cycle enable at the bus clock rate.
`timescale 1ns/10ps
`default_nettype none
module srpd_refresh_timer
    import srpd_pkg::*;
#(
    parameter int CNT_W = srpd_pkg::CNT_WIDTH,
    parameter int DIV   = srpd_pkg::TIMER_DIV
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Control
    input  wire logic             tick_i,
    input  wire logic             run_i,
    input  wire logic             cnt_we_i,
    input  wire logic             cor_we_i,
    input  wire logic [CNT_W-1:0] wdata_i,
    input  wire logic             cmf_clr_i,
    // State
    output logic      [CNT_W-1:0] cnt_o,
    output logic      [CNT_W-1:0] cor_o,
    output logic                  cmf_o,
    output logic                  match_o
);

    initial
    begin
        if (CNT_W < 1 || CNT_W > 16 || DIV < 1 || DIV > 255)
            $error("srpd_refresh_timer: unsupported parameters");
    end

    logic [7:0]       pre;
    logic [7:0]       next_pre;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] next_cor;
    logic             next_cmf;
    logic             next_match;
    logic             pre_tick;

    assign pre_tick = tick_i && run_i && (pre == 8'(DIV - 1));

    always_comb
    begin
        next_pre   = pre;
        next_cnt   = cnt_o;
        next_cor   = cor_o;
        next_cmf   = cmf_o;
        next_match = 1'b0;
        if (tick_i && run_i)
            next_pre = pre_tick ? 8'h00 : pre + 8'h01;
        if (pre_tick)
        begin
            if (cnt_o == cor_o)
            begin
                next_cnt   = '0;
                next_match = 1'b1;
            end
            else
                next_cnt = cnt_o + 1'b1;
        end
        if (cnt_we_i)
            next_cnt = wdata_i;
        if (cor_we_i)
            next_cor = wdata_i;
        if (cmf_clr_i)
            next_cmf = 1'b0;
        if (next_match)
            next_cmf = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre     <= 8'h00;
            cnt_o   <= '0;
            cor_o   <= '0;
            cmf_o   <= 1'b0;
            match_o <= 1'b0;
        end
        else
        begin
            pre     <= next_pre;
            cnt_o   <= next_cnt;
            cor_o   <= next_cor;
            cmf_o   <= next_cmf;
            match_o <= next_match;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_match_sets_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        (pre_tick && cnt_o == cor_o && !cnt_we_i) |=> (cmf_o && match_o && cnt_o == '0);
    endproperty
    a_match_sets_flag: assert property (p_match_sets_flag)
        else $error("compare match did not set flag");

endmodule : srpd_refresh_timer
`default_nettype wire

// [rtl/srpd_sdram_ctrl.sv]
// SDRAM refresh, power-down and launch-edge control with Wishbone registers.
// Assumes synchronous inputs on MCLK_I; bus clock out is MCLK_I divided by two.
`timescale 1ns/10ps
`default_nettype none
module srpd_sdram_ctrl
    import srpd_pkg::*;
#(
    parameter int ROW_W   = 13,
    parameter int COL_W   = 10,
    parameter int DATA_W  = 32,
    parameter int CAS_LAT = srpd_pkg::CAS_LATENCY
)
(
    // Clock and reset
    input  wire logic                          MCLK_I,
    input  wire logic                          ARST_N_I,
    // Wishbone slave
    input  wire logic                          WB_CYC_I,
    input  wire logic                          WB_STB_I,
    input  wire logic                          WB_WE_I,
    input  wire logic [3:0]                    WB_SEL_I,
    input  wire logic [srpd_pkg::WB_ADR_W-1:0] WB_ADR_I,
    input  wire logic [srpd_pkg::WB_DAT_W-1:0] WB_DAT_I,
    output logic      [srpd_pkg::WB_DAT_W-1:0] WB_DAT_O,
    output logic                               WB_ACK_O,
    // Access port
    input  wire logic                          REQ_I,
    input  wire logic                          REQ_WE_I,
    input  wire logic [ROW_W+COL_W-1:0]        REQ_ADDR_I,
    input  wire logic [DATA_W-1:0]             REQ_WDATA_I,
    input  wire logic                          OTHER_DONE_I,
    output logic                               REQ_ACK_O,
    output logic      [DATA_W-1:0]             REQ_RDATA_O,
    // SDRAM pins
    output logic                               SD_CLK_O,
    output logic                               SD_CKE_O,
    output logic                               SD_CS_N_O,
    output logic                               SD_RAS_N_O,
    output logic                               SD_CAS_N_O,
    output logic                               SD_WE_N_O,
    output logic      [ROW_W-1:0]              SD_ADDR_O,
    output logic      [DATA_W-1:0]             SD_DQ_O,
    output logic                               SD_DQ_OE_N_O,
    input  wire logic [DATA_W-1:0]             SD_DQ_I
);

    initial
    begin
        if (ROW_W < 11 || ROW_W > 16 || COL_W < 1 || COL_W > AP_BIT || CAS_LAT < 1
            || CAS_LAT > 3 || DATA_W < 1 || DATA_W > 32)
            $error("srpd_sdram_ctrl: unsupported parameters");
    end

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                res[8*i +: 8] = new_v[8*i +: 8];
        return res;
    endfunction : lane_merge

    // ------------------------------------------------------------------
    // Bus clock divider and launch phase
    // ------------------------------------------------------------------
    logic ck;
    logic launch;
    logic ctl_slow;

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            ck <= 1'b0;
        else
            ck <= !ck;
    end
    assign SD_CLK_O = ck;
    // Edge at which ck rises when low now, falls when high now
    assign launch = ctl_slow ? ck : !ck;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0]          ctrl;
    logic [31:0]          next_ctrl;
    logic                 cmf_armed;
    logic                 next_cmf_armed;
    logic                 next_ack;
    logic [31:0]          next_dat;
    logic                 ctl_deep;
    logic                 ctl_refen;
    logic                 ctl_rkind;
    logic                 ctl_pdaft;
    logic                 wr_cyc;
    logic                 rd_cyc;
    logic                 cmf_clr;
    logic                 cnt_we;
    logic                 cor_we;
    logic [31:0]          wr_val;
    logic [CNT_WIDTH-1:0] tmr_cnt;
    logic [CNT_WIDTH-1:0] tmr_cor;
    logic                 tmr_cmf;
    logic                 tmr_match;
    logic                 ref_pend;
    srpd_state_type       state;

    assign ctl_deep  = ctrl[BIT_DEEP];
    assign ctl_slow  = ctrl[BIT_SLOW];
    assign ctl_refen = ctrl[BIT_REFEN];
    assign ctl_rkind = ctrl[BIT_RKIND];
    assign ctl_pdaft = ctrl[BIT_PDAFT];
    assign wr_cyc    = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I;
    assign rd_cyc    = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I;
    assign wr_val    = lane_merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
    assign cnt_we    = wr_cyc && WB_ADR_I == ADR_RCNT && WB_SEL_I[0];
    assign cor_we    = wr_cyc && WB_ADR_I == ADR_RCOR && WB_SEL_I[0];
    assign cmf_clr   = wr_cyc && WB_ADR_I == ADR_RTCS && cmf_armed && WB_SEL_I[0]
                       && &WB_SEL_I[3:2] && wr_val[31:KEY_LSB] == RTCS_KEY && !wr_val[BIT_CMF];

    always_comb
    begin
        next_ctrl      = ctrl;
        next_cmf_armed = cmf_armed;
        next_ack       = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        next_dat       = 32'h0000_0000;
        if (wr_cyc && WB_ADR_I == ADR_CTRL)
        begin
            next_ctrl = lane_merge(ctrl, WB_DAT_I, WB_SEL_I);
            next_ctrl = next_ctrl & ((32'h0000_0001 << BIT_DEEP) | (32'h0000_0001 << BIT_SLOW)
                        | (32'h0000_0001 << BIT_REFEN) | (32'h0000_0001 << BIT_RKIND)
                        | (32'h0000_0001 << BIT_PDAFT));
        end
        if (cmf_clr)
            next_cmf_armed = 1'b0;
        if (rd_cyc)
        begin
            case (WB_ADR_I)
                ADR_CTRL: next_dat = ctrl;
                ADR_RTCS:
                begin
                    next_dat[BIT_CMF] = tmr_cmf;
                    if (tmr_cmf)
                        next_cmf_armed = 1'b1;
                end
                ADR_RCNT: next_dat[CNT_WIDTH-1:0] = tmr_cnt;
                ADR_RCOR: next_dat[CNT_WIDTH-1:0] = tmr_cor;
                ADR_STAT:
                begin
                    next_dat[STAT_CKE]   = SD_CKE_O;
                    next_dat[STAT_PD]    = (state == ST_PD);
                    next_dat[STAT_SELF]  = (state == ST_SELF);
                    next_dat[STAT_RPEND] = ref_pend;
                end
                default: next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ctrl      <= {32{CTRL_RESET}};
            cmf_armed <= 1'b0;
            WB_ACK_O  <= 1'b0;
            WB_DAT_O  <= 32'h0000_0000;
        end
        else
        begin
            ctrl      <= next_ctrl;
            cmf_armed <= next_cmf_armed;
            WB_ACK_O  <= next_ack;
            WB_DAT_O  <= next_dat;
        end
    end

    srpd_refresh_timer #(
        .CNT_W (CNT_WIDTH),
        .DIV   (TIMER_DIV)
    ) u_timer (
        .clk_i     (MCLK_I),
        .rst_n_i   (ARST_N_I),
        .tick_i    (!ck),
        .run_i     (ctl_refen && !ctl_rkind),
        .cnt_we_i  (cnt_we),
        .cor_we_i  (cor_we),
        .wdata_i   (WB_DAT_I[CNT_WIDTH-1:0]),
        .cmf_clr_i (cmf_clr),
        .cnt_o     (tmr_cnt),
        .cor_o     (tmr_cor),
        .cmf_o     (tmr_cmf),
        .match_o   (tmr_match)
    );

    // ------------------------------------------------------------------
    // SDRAM sequencer
    // ------------------------------------------------------------------
    srpd_state_type next_state;
    logic [2:0]     cmd;
    logic [2:0]     next_cmd;
    logic [1:0]     wait_cnt;
    logic [1:0]     next_wait;
    logic           next_ref_pend;
    logic           pd_pend;
    logic           next_pd_pend;
    logic           next_cke;
    logic           next_oe_n;
    logic           next_req_ack;
    logic [ROW_W-1:0]  next_addr;
    logic [DATA_W-1:0] next_dq;
    logic [DATA_W-1:0] next_rdata;
    logic           self_req;

    assign self_req = ctl_refen && ctl_rkind;

    always_comb
    begin
        next_state    = state;
        next_cmd      = cmd;
        next_wait     = wait_cnt;
        next_ref_pend = ref_pend;
        next_pd_pend  = pd_pend;
        next_cke      = SD_CKE_O;
        next_oe_n     = SD_DQ_OE_N_O;
        next_addr     = SD_ADDR_O;
        next_dq       = SD_DQ_O;
        next_rdata    = REQ_RDATA_O;
        next_req_ack  = 1'b0;
        if (launch)
        begin
            next_cmd  = CMD_NOP;
            next_oe_n = 1'b1;
            case (state)
                ST_IDLE:
                    if (self_req)
                    begin
                        next_cke   = 1'b0;
                        next_cmd   = ctl_deep ? CMD_BST : CMD_REF;
                        next_state = ST_SELF;
                    end
                    else if (ref_pend)
                    begin
                        next_cmd      = CMD_REF;
                        next_ref_pend = 1'b0;
                    end
                    else if (REQ_I && !REQ_ACK_O)
                    begin
                        next_cmd     = CMD_ACT;
                        next_addr    = REQ_ADDR_I[COL_W +: ROW_W];
                        next_pd_pend = 1'b0;
                        next_state   = ST_RW;
                    end
                    else if (pd_pend && ctl_pdaft)
                    begin
                        next_cke     = 1'b0;
                        next_pd_pend = 1'b0;
                        next_state   = ST_PD;
                    end
                ST_RW:
                begin
                    next_addr         = '0;
                    next_addr[COL_W-1:0] = REQ_ADDR_I[COL_W-1:0];
                    next_addr[AP_BIT] = 1'b1;
                    if (REQ_WE_I)
                    begin
                        next_cmd     = CMD_WRITE;
                        next_dq      = REQ_WDATA_I;
                        next_oe_n    = 1'b0;
                        next_req_ack = 1'b1;
                        next_state   = ST_IDLE;
                    end
                    else
                    begin
                        next_cmd   = CMD_READ;
                        next_wait  = 2'(CAS_LAT - 1);
                        next_state = ST_RD;
                    end
                end
                ST_RD:
                    if (wait_cnt == 2'h0)
                    begin
                        next_rdata   = SD_DQ_I;
                        next_req_ack = 1'b1;
                        next_state   = ST_IDLE;
                    end
                    else
                        next_wait = wait_cnt - 2'h1;
                ST_PD:
                    if (REQ_I || ref_pend || self_req || !ctl_pdaft)
                    begin
                        next_cke   = 1'b1;
                        next_state = ST_WAKE;
                    end
                ST_SELF:
                    if (!self_req)
                    begin
                        next_cke   = 1'b1;
                        next_state = ST_WAKE;
                    end
                ST_WAKE: next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
        if (!ctl_refen || ctl_rkind)
            next_ref_pend = 1'b0;
        if (tmr_match && ctl_refen && !ctl_rkind)
            next_ref_pend = 1'b1;
        if (!ctl_pdaft)
            next_pd_pend = 1'b0;
        if (OTHER_DONE_I && ctl_pdaft)
            next_pd_pend = 1'b1;
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state        <= ST_IDLE;
            cmd          <= CMD_NOP;
            wait_cnt     <= 2'h0;
            ref_pend     <= 1'b0;
            pd_pend      <= 1'b0;
            SD_CKE_O     <= 1'b1;
            SD_DQ_OE_N_O <= 1'b1;
            SD_ADDR_O    <= '0;
            SD_DQ_O      <= '0;
            REQ_RDATA_O  <= '0;
            REQ_ACK_O    <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            cmd          <= next_cmd;
            wait_cnt     <= next_wait;
            ref_pend     <= next_ref_pend;
            pd_pend      <= next_pd_pend;
            SD_CKE_O     <= next_cke;
            SD_DQ_OE_N_O <= next_oe_n;
            SD_ADDR_O    <= next_addr;
            SD_DQ_O      <= next_dq;
            REQ_RDATA_O  <= next_rdata;
            REQ_ACK_O    <= next_req_ack;
        end
    end

    assign SD_CS_N_O  = 1'b0;
    assign SD_RAS_N_O = cmd[2];
    assign SD_CAS_N_O = cmd[1];
    assign SD_WE_N_O  = cmd[0];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic first_done;
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            first_done <= 1'b0;
        else
            first_done <= 1'b1;
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);

    property p_slow_fall;
        (ctl_slow && $past(ctl_slow) && $changed(cmd)) |-> ($past(ck) && !SD_CLK_O);
    endproperty
    a_slow_fall: assert property (p_slow_fall)
        else $error("slow mode command not on falling edge");

    property p_norm_rise;
        (!ctl_slow && !$past(ctl_slow) && $changed(cmd)) |-> (!$past(ck) && SD_CLK_O);
    endproperty
    a_norm_rise: assert property (p_norm_rise)
        else $error("normal command not on rising edge");

    property p_slow_hold;
        (ctl_slow && $changed(cmd)) |=> $stable(cmd) ##1 (SD_CLK_O == 1'b0);
    endproperty
    a_slow_hold: assert property (p_slow_hold)
        else $error("slow mode hold not extended");

    property p_no_ref_off;
        ($changed(cmd) && cmd == CMD_REF) |-> $past(ctl_refen);
    endproperty
    a_no_ref_off: assert property (p_no_ref_off)
        else $error("refresh issued while disabled");

    property p_self_now;
        (state == ST_IDLE && launch && self_req && !ctl_deep) |=> (state == ST_SELF && !SD_CKE_O && cmd == CMD_REF);
    endproperty
    a_self_now: assert property (p_self_now)
        else $error("self-refresh not entered at once");

    property p_auto_ref;
        (tmr_match && ctl_refen && !ctl_rkind && state == ST_IDLE) |-> ##[1:4] (cmd == CMD_REF);
    endproperty
    a_auto_ref: assert property (p_auto_ref)
        else $error("auto-refresh not issued after match");

    property p_pd_entry;
        (state == ST_IDLE && launch && pd_pend && ctl_pdaft && !self_req && !ref_pend && !REQ_I)
            |=> (!SD_CKE_O && state == ST_PD);
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down not entered");

    property p_no_pd;
        (!ctl_pdaft && state != ST_PD) |=> (state != ST_PD);
    endproperty
    a_no_pd: assert property (p_no_pd)
        else $error("power-down entered while disabled");

    property p_deep;
        (state == ST_IDLE && launch && self_req && ctl_deep) |=> (cmd == CMD_BST && !SD_CKE_O);
    endproperty
    a_deep: assert property (p_deep)
        else $error("deep power-down command missing");

    property p_reset_zero;
        !first_done |-> (ctrl == 32'h0000_0000 && SD_CKE_O);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("control bits not zero after reset");

endmodule : srpd_sdram_ctrl
`default_nettype wire

// [sim/srpd_sdram_model.sv]
// SDRAM stand-in: keeps one word, returns it after a read command.
// Assumes commands held per launch and read data taken CAS latency launches on.
`timescale 1ns/10ps
`default_nettype none
module srpd_sdram_model
    import srpd_pkg::*;
(
    // Command and address pins
    input  wire logic        clk_i,
    input  wire logic        cs_n_i,
    input  wire logic [2:0]  cmd_i,
    input  wire logic        cke_i,
    input  wire logic [12:0] addr_i,
    // Data pins
    input  wire logic        oe_n_i,
    input  wire logic [31:0] dq_i,
    output logic      [31:0] dq_o
);
    logic [31:0] mem = 32'h0;
    logic [7:0]  win = 8'h0;
    logic        sel;
    // Only selected, auto-precharge accesses count
    assign sel = cke_i && !cs_n_i && addr_i[AP_BIT];
    always @(posedge clk_i)
    begin
        if (sel && !oe_n_i && cmd_i == CMD_WRITE)
            mem <= dq_i;
        // Word valid only at the launch CAS latency after READ
        win <= (sel && cmd_i == CMD_READ) ? 8'(1 << (2 * CAS_LATENCY - 3)) : win >> 1;
    end
    // Released bus shows inverted word, never stale data
    assign dq_o = win[0] ? mem : ~mem;
endmodule : srpd_sdram_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench of the SDRAM refresh and power-down slice.
// Assumes the partner model on the SDRAM pins and Wishbone registers.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import srpd_pkg::*;
    logic        MCLK_I = 0, ARST_N_I = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic        REQ_I = 0, REQ_WE_I = 0, OTHER_DONE_I = 0, WB_ACK_O, REQ_ACK_O;
    logic        SD_CLK_O, SD_CKE_O, SD_CS_N_O, SD_RAS_N_O, SD_CAS_N_O, SD_WE_N_O, SD_DQ_OE_N_O;
    logic [3:0]  WB_SEL_I = 4'hf;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [31:0] WB_DAT_I = 32'h0, REQ_WDATA_I = 32'h0, WB_DAT_O, REQ_RDATA_O, SD_DQ_O, SD_DQ_I;
    logic [22:0] REQ_ADDR_I = 23'h0;
    logic [12:0] SD_ADDR_O;
    logic [31:0] rd;
    int          errors = 0, compares = 0, n;
    // Control write, read-back, clock enable after settling
    logic [31:0] rows [5][3] = '{'{32'h0c00, 32'h0c00, 32'h0}, '{32'h2c00, 32'h2c00, 32'h0},
        '{32'h0800, 32'h0800, 32'h1}, '{32'hffffffff, 32'h3e00, 32'h0}, '{32'h0, 32'h0, 32'h1}};
    srpd_sdram_ctrl u_dut (.MCLK_I, .ARST_N_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_SEL_I,
        .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .REQ_I, .REQ_WE_I, .REQ_ADDR_I, .REQ_WDATA_I,
        .OTHER_DONE_I, .REQ_ACK_O, .REQ_RDATA_O, .SD_CLK_O, .SD_CKE_O, .SD_CS_N_O, .SD_RAS_N_O,
        .SD_CAS_N_O, .SD_WE_N_O, .SD_ADDR_O, .SD_DQ_O, .SD_DQ_OE_N_O, .SD_DQ_I);
    srpd_sdram_model u_mem (.clk_i(MCLK_I), .cs_n_i(SD_CS_N_O),
        .cmd_i({SD_RAS_N_O, SD_CAS_N_O, SD_WE_N_O}), .cke_i(SD_CKE_O), .addr_i(SD_ADDR_O),
        .oe_n_i(SD_DQ_OE_N_O), .dq_i(SD_DQ_O), .dq_o(SD_DQ_I));
    always #2 MCLK_I = ~MCLK_I;
    task automatic close_out;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_v(ref logic s, input logic v);
        n = 0;
        do
        begin
            @(posedge MCLK_I);
            n++;
        end while (s !== v && n < 80);
        if (s !== v)
        begin
            errors++;
            close_out();
        end
    endtask : wait_v
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
        wait_v(WB_ACK_O, 1'b1);
        rd = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
    endtask : wb
    task automatic acc(input logic we, input logic [31:0] d);
        @(posedge MCLK_I);
        {REQ_I, REQ_WE_I, REQ_ADDR_I, REQ_WDATA_I} <= {1'b1, we, 23'h12345, d};
        wait_v(REQ_ACK_O, 1'b1);
        rd = REQ_RDATA_O;
        REQ_I <= 1'b0;
    endtask : acc
    task automatic poke;
        @(posedge MCLK_I);
        OTHER_DONE_I <= 1'b1;
        @(posedge MCLK_I);
        OTHER_DONE_I <= 1'b0;
    endtask : poke
    initial
    begin
        repeat (5) @(posedge MCLK_I);
        ARST_N_I <= 1'b1;
        wb(0, ADR_CTRL, 0);
        chk(rd, 32'h0);
        chk({31'h0, SD_CKE_O}, 32'h1);
        wb(0, 8'h20, 0);
        chk(rd, 32'h0);
        foreach (rows[i])
        begin
            wb(1, ADR_CTRL, rows[i][0]);
            wb(0, ADR_CTRL, 0);
            chk(rd, rows[i][1]);
            wait_v(SD_CKE_O, rows[i][2][0]);
            chk({31'h0, SD_CKE_O}, rows[i][2]);
        end
        wb(0, ADR_RTCS, 0);
        wb(1, ADR_RTCS, {RTCS_KEY, 16'h0000});
        wb(0, ADR_RTCS, 0);
        chk(rd, 32'h0);
        wb(1, ADR_RCOR, 32'h3);
        wb(1, ADR_CTRL, 32'h0800);
        repeat (80) @(posedge MCLK_I);
        wb(0, ADR_RTCS, 0);
        chk(rd & 32'h80, 32'h80);
        wb(1, ADR_CTRL, 32'h0200);
        poke();
        wait_v(SD_CKE_O, 1'b0);
        chk({31'h0, SD_CKE_O}, 32'h0);
        acc(1, 32'hc0ffee01);
        acc(0, 32'h0);
        chk(rd, 32'hc0ffee01);
        // Slow timing chosen as for a low-rate memory clock
        wb(1, ADR_CTRL, 32'h1000);
        acc(1, 32'h5a3c0f96);
        acc(0, 32'h0);
        chk(rd, 32'h5a3c0f96);
        poke();
        repeat (30) @(posedge MCLK_I);
        chk({31'h0, SD_CKE_O}, 32'h1);
        // Reset in the middle of self-refresh
        wb(1, ADR_CTRL, 32'h0c00);
        wait_v(SD_CKE_O, 1'b0);
        ARST_N_I <= 1'b0;
        @(posedge MCLK_I);
        chk({31'h0, SD_CKE_O}, 32'h1);
        ARST_N_I <= 1'b1;
        wb(0, ADR_CTRL, 0);
        chk(rd, 32'h0);
        close_out();
    end
endmodule : tb
`default_nettype wire
